//--- design/can_filt_pkg.sv
// Package: constants for the receive filter and error-state block
// Assumes: 32-bit APB register bus, one clock domain
package can_filt_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_COUNTERS = 8'h08;
    localparam logic [7:0] OFF_SEARCH   = 8'h0C;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h10;
    localparam logic [7:0] OFF_IRQ_FLAG = 8'h14;
    localparam logic [7:0] OFF_MASK0    = 8'h40;
    localparam logic [11:0] OFF_RXID0   = 12'h100;  // Mailbox id page

    // Identifier width and counter limits
    localparam int         ID_W        = 11;
    localparam logic [8:0] PASSIVE_LIM = 9'h080;
    localparam logic [8:0] BUSOFF_LIM  = 9'h0FF;
    localparam logic [3:0] IDLE_BITS   = 4'hB;
    localparam logic [7:0] IDLE_SEQS   = 8'h80;

    // Reset values
    localparam logic [10:0] MASK_RST = 11'h7FF;
    localparam logic [10:0] RXID_RST = 11'h000;

    // Error state codes
    typedef enum logic [1:0]
    {
        ST_ACTIVE  = 2'b00,
        ST_PASSIVE = 2'b01,
        ST_BUSOFF  = 2'b10
    } err_state_t;

endpackage : can_filt_pkg

//--- design/id_search_helper.sv
// Search-support reformatter: stored identifier to table indexes
// Assumes: identifier already in mailbox format, combinational use
`timescale 1ns/1ns
module id_search_helper
(
    // Identifier in
    input  wire logic [10:0] id_in,
    // Table indexes out
    output logic      [7:0]  table_byte_index,
    output logic      [7:0]  table_bit_onehot
);
    import can_filt_pkg::*;

    // Upper bits become the byte address [R06]
    assign table_byte_index = id_in[10:3];
    // Lowest three bits decoded to one set bit [R07]
    assign table_bit_onehot = 8'h01 << id_in[2:0];

endmodule : id_search_helper

//--- design/can_rx_filter_error_state.sv
// Receive acceptance filter, search-support and error-state tracking
// Assumes: protocol engine supplies event pulses and sampled bit levels
//
// How it works
// R01: One mask per group of four mailboxes
// R02: Mask zero ignores bit, one compares
// R03: Accept when all unmasked bits match
// R04: Identifiers and masks are eleven bits
// R05: Software writes identifier in mailbox format
// R06: Low readout byte is table byte address
// R07: High readout byte is one-hot bit index
// R08: Transmit error bumps transmit counter
// R09: Receive error bumps receive counter
// R10: Successful frame decrements its counter
// R11: Active and passive still communicate
// R12: Active node sends active error flag
// R13: Counter over threshold enters error-passive
// R14: Passive node sends no active flags
// R15: Transmit counter over limit enters bus-off
// R16: Bus-off blocks traffic; recovers after idle sequences
// R17: Status flags readable by software
// R18: Retry and error frames handled in hardware
// R19: Error interrupt raised on state change; only entry to passive or bus-off is flagged, not return to active
// R20: Software reinitialises after bus-off recovery
// R21: Separate enables per error, passive, bus-off
// R22: Two-bit state updates cycle after crossing
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module can_rx_filter_error_state
#(
    parameter int N_MBOX = 32
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Receive side from protocol engine
    input  wire logic        rx_id_valid,
    input  wire logic [10:0] rx_id,
    output logic [N_MBOX-1:0] rx_accept,
    // Error events from protocol engine
    input  wire logic        tx_err,
    input  wire logic        rx_err,
    input  wire logic        tx_ok,
    input  wire logic        rx_ok,
    input  wire logic        recessive_bit,
    input  wire logic        bit_tick,
    input  wire logic        retry_req,
    // Status to protocol engine
    output logic             tx_allowed,
    output logic             rx_allowed,
    output logic             send_active_flag,
    output logic             auto_retry,
    output logic             irq_err
);
    import can_filt_pkg::*;

    localparam int N_GRP = N_MBOX / 4;

    //****************************************************************
    // Register state
    //****************************************************************
    logic [10:0] mask_ff [N_GRP];   // One mask per group
    logic [10:0] rxid_ff [N_MBOX];  // Mailbox receive ids
    logic [10:0] search_ff;          // Search-support input
    logic [2:0]  irq_en_ff;          // Error, passive, bus-off enables
    logic [2:0]  irq_flag_ff;        // Sticky event flags
    logic [8:0]  tec_ff;             // Transmit error counter
    logic [7:0]  rec_ff;             // Receive error counter
    err_state_t  state_ff;           // Encoded error state
    logic [3:0]  idle_cnt_ff;        // Recessive bit run
    logic [7:0]  seq_cnt_ff;         // Idle sequences seen
    logic [N_MBOX-1:0] accept_ff;   // Registered accept vector
    logic        retry_en_ff;        // Automatic retry enable
    logic        rec_ok_ff;          // Bus-off recovery flag

    //****************************************************************
    // Synchronised bus level
    //****************************************************************
    logic rbit_s1_ff;   // First stage
    logic rbit_s2_ff;   // Second stage

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rbit_s1_ff <= 1'b1;
            rbit_s2_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            rbit_s1_ff <= recessive_bit;
            rbit_s2_ff <= rbit_s1_ff;
        end
    end

    //****************************************************************
    // APB decode
    //****************************************************************
    wire        acc     = psel && penable;
    wire [7:0]  a       = paddr[7:0];
    wire        is_mask = paddr[11:8] == 4'h0 && a >= OFF_MASK0
                          && a < OFF_MASK0 + 8'(4 * N_GRP);
    wire        is_rxid = paddr[11:8] == OFF_RXID0[11:8];
    wire [4:0]  mbx     = paddr[6:2];
    wire [2:0]  grp     = 3'(a[6:2] - OFF_MASK0[6:2]);
    wire        known   = (paddr[11:8] == 4'h0 && (a <= OFF_IRQ_FLAG
                          || is_mask)) || is_rxid;
    // Writes to unmapped addresses are dropped
    wire        wr      = acc && pwrite && clk_en && known;

    assign pready  = 1'b1;
    assign pslverr = acc && !known;

    // Search-support readout
    logic [7:0] byte_idx;
    logic [7:0] bit_hot;

    id_search_helper u_search
    (
        .id_in            (search_ff),
        .table_byte_index (byte_idx),
        .table_bit_onehot (bit_hot)
    );

    //****************************************************************
    // Acceptance filter
    //****************************************************************
    function automatic logic id_match(input logic [10:0] id,
                                      input logic [10:0] ref_id,
                                      input logic [10:0] m);
        // Only bits with mask one must agree [R02] [R04]
        return ((id ^ ref_id) & m) == 11'h000;
    endfunction : id_match

    logic [N_MBOX-1:0] nxt_accept;
    always_comb
    begin
        nxt_accept = '0;
        for (int i = 0; i < N_MBOX; i++)
        begin
            // Group mask shared by four mailboxes [R01] [R03]
            nxt_accept[i] = rx_id_valid && rx_allowed
                            && id_match(rx_id, rxid_ff[i], mask_ff[i/4]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            accept_ff <= '0;
        else if (clk_en)
            accept_ff <= nxt_accept;
    end
    assign rx_accept = accept_ff;

    //****************************************************************
    // Configuration writes
    //****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int g = 0; g < N_GRP; g++)
                mask_ff[g] <= MASK_RST;
            for (int m = 0; m < N_MBOX; m++)
                rxid_ff[m] <= RXID_RST;
            search_ff   <= 11'h000;
            irq_en_ff   <= 3'h0;
            retry_en_ff <= 1'b1;
        end
        else if (wr)
        begin
            if (is_mask)
                mask_ff[grp] <= pwdata[10:0];
            else if (is_rxid)
                rxid_ff[mbx] <= pwdata[10:0];
            else if (a == OFF_SEARCH)
                search_ff <= pwdata[10:0];  // Mailbox format [R05]
            else if (a == OFF_IRQ_EN)
                irq_en_ff <= pwdata[2:0];
            else if (a == OFF_CTRL)
                retry_en_ff <= pwdata[0];
        end
    end

    //****************************************************************
    // Error counters
    //****************************************************************
    wire busoff = state_ff == ST_BUSOFF;
    wire tx_up  = tx_err && !busoff;   // [R08]
    wire rx_up  = rx_err && !busoff;   // [R09]
    wire idle_done = seq_cnt_ff == IDLE_SEQS - 8'h01
                     && idle_cnt_ff == IDLE_BITS - 4'h1
                     && bit_tick && rbit_s2_ff;

    logic [8:0] nxt_tec;
    logic [7:0] nxt_rec;
    always_comb
    begin
        nxt_tec = tec_ff;
        nxt_rec = rec_ff;
        if (idle_done)
        begin
            nxt_tec = 9'h000;
            nxt_rec = 8'h00;
        end
        else
        begin
            if (tx_up && tec_ff != 9'h1FF)
                nxt_tec = tec_ff + 9'h001;
            else if (tx_ok && tec_ff != 9'h000)
                nxt_tec = tec_ff - 9'h001;   // [R10]
            if (rx_up && rec_ff != 8'hFF)
                nxt_rec = rec_ff + 8'h01;
            else if (rx_ok && !busoff && rec_ff != 8'h00)
                nxt_rec = rec_ff - 8'h01;    // [R10]
        end
    end

    // Bus-off idle counting: 11 recessive bits, 128 times [R16]
    logic [3:0] nxt_idle;
    logic [7:0] nxt_seq;
    always_comb
    begin
        nxt_idle = idle_cnt_ff;
        nxt_seq  = seq_cnt_ff;
        if (!busoff || idle_done)
        begin
            nxt_idle = 4'h0;
            nxt_seq  = 8'h00;
        end
        else if (bit_tick)
        begin
            if (!rbit_s2_ff)
                nxt_idle = 4'h0;
            else if (idle_cnt_ff == IDLE_BITS - 4'h1)
            begin
                nxt_idle = 4'h0;
                nxt_seq  = seq_cnt_ff + 8'h01;
            end
            else
                nxt_idle = idle_cnt_ff + 4'h1;
        end
    end

    // State from counters, registered one cycle later [R22]
    err_state_t nxt_state;
    always_comb
    begin
        nxt_state = state_ff;
        if (busoff)
            nxt_state = idle_done ? ST_ACTIVE : ST_BUSOFF;
        else if (tec_ff > BUSOFF_LIM)
            nxt_state = ST_BUSOFF;                       // [R15]
        else if (tec_ff > PASSIVE_LIM || {1'b0, rec_ff} > PASSIVE_LIM)
            nxt_state = ST_PASSIVE;                      // [R13]
        else
            nxt_state = ST_ACTIVE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tec_ff      <= 9'h000;
            rec_ff      <= 8'h00;
            state_ff    <= ST_ACTIVE;
            idle_cnt_ff <= 4'h0;
            seq_cnt_ff  <= 8'h00;
        end
        else if (clk_en)
        begin
            tec_ff      <= nxt_tec;
            rec_ff      <= nxt_rec;
            state_ff    <= nxt_state;
            idle_cnt_ff <= nxt_idle;
            seq_cnt_ff  <= nxt_seq;
        end
    end

    //****************************************************************
    // Interrupt flags; set wins over write-one-to-clear
    //****************************************************************
    wire [2:0] ev = {nxt_state == ST_BUSOFF && !busoff,
                     nxt_state == ST_PASSIVE && state_ff == ST_ACTIVE,
                     tx_up || rx_up};
    wire [2:0] clr = (wr && a == OFF_IRQ_FLAG) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_flag_ff <= 3'h0;
            rec_ok_ff   <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_flag_ff <= (irq_flag_ff & ~clr) | ev;   // [R21]
            // Recovery flag tells software to reinitialise [R20]
            if (idle_done)
                rec_ok_ff <= 1'b1;
            else if (clr[2])
                rec_ok_ff <= 1'b0;
        end
    end

    // One line, per-cause enables [R19] [R21]
    assign irq_err = |(irq_flag_ff & irq_en_ff);

    //****************************************************************
    // Protocol-engine controls
    //****************************************************************
    assign tx_allowed       = !busoff;                          // [R11]
    assign rx_allowed       = !busoff;                          // [R16]
    assign send_active_flag = state_ff == ST_ACTIVE;        // [R12] [R14]
    assign auto_retry       = retry_req && retry_en_ff && !busoff; // [R18]

    //****************************************************************
    // Read data mux
    //****************************************************************
    logic [31:0] rd;
    always_comb
    begin
        rd = 32'h0000_0000;
        if (!known)
            rd = 32'h0000_0000;             // Unmapped reads as zero
        else if (is_mask)
            rd = {21'h0, mask_ff[grp]};
        else if (is_rxid)
            rd = {21'h0, rxid_ff[mbx]};
        else if (a == OFF_STATUS)
            rd = {27'h0, rec_ok_ff, busoff, state_ff == ST_PASSIVE,
                  state_ff == ST_ACTIVE, 1'b0} | {30'h0, state_ff}
                  & 32'h0000_0003 | 32'h0000_0000;  // [R17]
        else if (a == OFF_COUNTERS)
            rd = {15'h0, tec_ff, rec_ff};
        else if (a == OFF_SEARCH)
            rd = {16'h0, bit_hot, byte_idx};        // [R06] [R07]
        else if (a == OFF_IRQ_EN)
            rd = {29'h0, irq_en_ff};
        else if (a == OFF_IRQ_FLAG)
            rd = {29'h0, irq_flag_ff};
        else if (a == OFF_CTRL)
            rd = {31'h0, retry_en_ff};
    end
    assign prdata = rd;

    //****************************************************************
    // Assertions
    //****************************************************************
    a_busoff_blocks: assert property (@(posedge pclk) // [R16]
        disable iff (!presetn) busoff |-> !tx_allowed && !rx_allowed
        && (rx_accept == '0 || $past(!busoff)))
        else $error("traffic while bus-off");
    a_tec_up: assert property (@(posedge pclk) // [R08]
        disable iff (!presetn) clk_en && tx_up && !idle_done
        && tec_ff < 9'h1FF |=> tec_ff == $past(tec_ff) + 9'h001)
        else $error("tec did not increment");
    a_rec_up: assert property (@(posedge pclk) // [R09]
        disable iff (!presetn) clk_en && rx_up && !idle_done
        && rec_ff < 8'hFF |=> rec_ff == $past(rec_ff) + 8'h01)
        else $error("rec did not increment");
    a_tec_down: assert property (@(posedge pclk) // [R10]
        disable iff (!presetn) clk_en && tx_ok && !tx_err && !idle_done
        && tec_ff != 9'h000 |=> tec_ff == $past(tec_ff) - 9'h001)
        else $error("tec did not decrement");
    a_passive_in: assert property (@(posedge pclk) // [R13]
        disable iff (!presetn) clk_en && !busoff && tec_ff <= BUSOFF_LIM
        && (tec_ff > PASSIVE_LIM || {1'b0, rec_ff} > PASSIVE_LIM)
        |=> state_ff == ST_PASSIVE)
        else $error("no passive entry");
    a_busoff_in: assert property (@(posedge pclk) // [R15]
        disable iff (!presetn) clk_en && tec_ff > BUSOFF_LIM && !idle_done
        |=> state_ff == ST_BUSOFF)
        else $error("no bus-off entry");
    a_flag_active: assert property (@(posedge pclk) // [R12] [R14]
        disable iff (!presetn) send_active_flag |-> $past(idle_done)
        || $past(tec_ff) <= PASSIVE_LIM && $past(rec_ff) <= 8'h80)
        else $error("active flag with counters over threshold");
    a_search_out: assert property (@(posedge pclk) // [R06] [R07]
        disable iff (!presetn)
        $countones(bit_hot) == 1 && bit_hot[search_ff[2:0]]
        && byte_idx == search_ff[10:3])
        else $error("search readout malformed");
    c_busoff: cover property (@(posedge pclk) state_ff == ST_BUSOFF);
    c_recover: cover property (@(posedge pclk) idle_done);
    c_accept: cover property (@(posedge pclk) |rx_accept);

endmodule : can_rx_filter_error_state

//--- dv/can_node_model.sv
// Far-side CAN node model: event pulses, frame IDs, idle bus
// Assumes: driven from the bench by task calls, one clock domain
`timescale 1ns/1ns
module can_node_model
(
    // Clock
    input  wire logic        pclk,
    // Traffic toward the block
    output logic             tx_err,
    output logic             rx_err,
    output logic             tx_ok,
    output logic             rx_ok,
    output logic             rx_id_valid,
    output logic [10:0]      rx_id,
    output logic             recessive_bit,
    output logic             bit_tick,
    output logic             retry_req
);
    // Quiet, dominant-driven bus at time zero
    initial
    begin
        {tx_err, rx_err, tx_ok, rx_ok, rx_id_valid} = 5'h00;
        {recessive_bit, bit_tick, retry_req} = 3'h0;
        rx_id = 11'h000;
    end

    // One-cycle event: 0 tx error, 1 rx error, 2 tx ok, 3 rx ok
    task automatic ev(input int k);
        @(posedge pclk);
        {tx_err, rx_err, tx_ok, rx_ok} <= 4'h8 >> k;
        @(posedge pclk);
        {tx_err, rx_err, tx_ok, rx_ok} <= 4'h0;
    endtask : ev

    // Identifier for one cycle, then inverted so nothing stale lingers
    task automatic send_id(input logic [10:0] id);
        @(posedge pclk);
        rx_id_valid <= 1'b1;
        rx_id       <= id;
        @(posedge pclk);
        rx_id_valid <= 1'b0;
        rx_id       <= ~id;
    endtask : send_id

    // Retry request level
    task automatic retry(input logic v);
        @(posedge pclk);
        retry_req <= v;
    endtask : retry

    // Idle recessive bus: runs of eleven recessive bit times
    task automatic idle(input int runs);
        @(posedge pclk);
        recessive_bit <= 1'b1;
        repeat (3) @(posedge pclk);
        repeat (runs * 11)
        begin
            @(posedge pclk);
            bit_tick <= 1'b1;
            @(posedge pclk);
            bit_tick <= 1'b0;
        end
    endtask : idle
endmodule : can_node_model

//--- dv/can_rx_filter_error_state_test.sv
// Bench: filter, search and error-state checks against a model
// Assumes: far-side node model, APB master tasks, 125 MHz clock
`timescale 1ns/1ns
module can_rx_filter_error_state_test;
    import can_filt_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, rx_accept;
    logic tx_err, rx_err, tx_ok, rx_ok, rx_id_valid, recessive_bit;
    logic bit_tick, retry_req, tx_allowed, rx_allowed, rerr;
    logic send_active_flag, auto_retry, irq_err;
    logic [10:0] rx_id, id;
    logic [10:0] mask [8];
    logic [10:0] rxid [32];
    int failures, compares, tec, rec;
    bit boff;

    can_rx_filter_error_state uut
    (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_id_valid(rx_id_valid), .rx_id(rx_id),
        .rx_accept(rx_accept), .tx_err(tx_err), .rx_err(rx_err),
        .tx_ok(tx_ok), .rx_ok(rx_ok), .recessive_bit(recessive_bit),
        .bit_tick(bit_tick), .retry_req(retry_req),
        .tx_allowed(tx_allowed), .rx_allowed(rx_allowed),
        .send_active_flag(send_active_flag), .auto_retry(auto_retry),
        .irq_err(irq_err)
    );
    can_node_model node
    (
        .pclk(pclk), .tx_err(tx_err), .rx_err(rx_err), .tx_ok(tx_ok),
        .rx_ok(rx_ok), .rx_id_valid(rx_id_valid), .rx_id(rx_id),
        .recessive_bit(recessive_bit), .bit_tick(bit_tick),
        .retry_req(retry_req)
    );

    // 8 ns clock
    always #4 pclk = ~pclk;

    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // APB transfer: setup, access until pready, then release
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            failures++;
            wrap_up();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Filter model: compare every mailbox for one identifier
    task automatic filt(input logic [10:0] v);
        logic [31:0] e;
        for (int i = 0; i < 32; i++)
            e[i] = (((v ^ rxid[i]) & mask[i/4]) == 11'h000);
        node.send_id(v);
        #1;
        chk("rx_accept", e, rx_accept);
    endtask : filt

    // Error events into model and block
    task automatic ev(input int k, input int n);
        repeat (n)
        begin
            node.ev(k);
            if (!boff)
                case (k)
                    0: tec++;
                    1: rec++;
                    2: tec = (tec > 0) ? tec - 1 : 0;
                    default: rec = (rec > 0) ? rec - 1 : 0;
                endcase
            boff = boff || tec > 255;
        end
    endtask : ev

    // State, counters and status against the model
    task automatic st;
        logic pas;
        pas = !boff && (tec > 128 || rec > 128);
        repeat (2) @(posedge pclk);
        #1;
        chk("active_flag", 32'(!pas && !boff), 32'(send_active_flag));
        chk("tx_allowed", 32'(!boff), 32'(tx_allowed));
        chk("rx_allowed", 32'(!boff), 32'(rx_allowed));
        rd(OFF_COUNTERS);
        chk("counters", 32'({tec[8:0], rec[7:0]}), rdat);
        rd(OFF_STATUS);
        chk("status", 32'({boff, pas}), 32'(rdat[3:2]));
    endtask : st

    initial
    begin
        {pclk, presetn, psel, penable, pwrite} = 5'h00;
        paddr  = 12'h000;
        pwdata = 32'h0000_0000;
        {failures, compares, tec, rec, boff} = '0;
        foreach (mask[g]) mask[g] = MASK_RST;
        foreach (rxid[m]) rxid[m] = RXID_RST;
        void'($urandom(99));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        st();
        rd(OFF_CTRL);
        chk("ctrl", 32'h0000_0001, rdat);
        chk("irq_reset", 32'h0, 32'(irq_err));
        apb(1'b0, 12'h300, 32'h0);
        chk("slverr", 32'h1, 32'(rerr));
        chk("unmapped", 32'h0, rdat);
        // Mask groups and mailbox identifiers
        mask[0] = 11'h7F8;
        mask[1] = 11'h000;
        mask[7] = 11'($urandom);
        rxid[0] = 11'h700;
        rxid[1] = 11'h705;
        rxid[4] = 11'h123;
        rxid[31] = 11'($urandom);
        foreach (mask[g]) apb(1'b1, 12'(OFF_MASK0 + 4 * g), 32'(mask[g]));
        foreach (rxid[m]) apb(1'b1, 12'(OFF_RXID0 + 4 * m), 32'(rxid[m]));
        for (int i = 0; i < 9; i++)
            filt(11'h700 + 11'(i));
        filt(11'h000);
        filt(rxid[31]);
        repeat (4) filt(11'($urandom));
        // Search-support readout
        repeat (6)
        begin
            id = 11'($urandom);
            apb(1'b1, OFF_SEARCH, 32'(id));
            rd(OFF_SEARCH);
            chk("search", {16'h0, 8'h01 << id[2:0], id[10:3]}, rdat);
        end
        // Hardware retry gating
        node.retry(1'b1);
        #1;
        chk("retry_on", 32'h1, 32'(auto_retry));
        apb(1'b1, OFF_CTRL, 32'h0);
        #1;
        chk("retry_off", 32'h0, 32'(auto_retry));
        apb(1'b1, OFF_CTRL, 32'h1);
        // Counting, then the passive boundary
        ev(1, 3);
        ev(3, 1);
        ev(0, 2);
        ev(2, 1);
        st();
        ev(0, 127);
        st();
        ev(0, 1);
        #1;
        chk("late_state", 32'h1, 32'(send_active_flag));
        @(posedge pclk);
        #1;
        chk("passive", 32'h0, 32'(send_active_flag));
        st();
        chk("irq_masked", 32'h0, 32'(irq_err));
        apb(1'b1, OFF_IRQ_EN, 32'h2);
        #1;
        chk("irq_passive", 32'h1, 32'(irq_err));
        apb(1'b1, OFF_IRQ_FLAG, 32'h2);
        #1;
        chk("irq_clear", 32'h0, 32'(irq_err));
        apb(1'b1, OFF_IRQ_EN, 32'h4);
        // Bus-off boundary and recovery
        ev(0, 126);
        st();
        ev(0, 1);
        st();
        ev(1, 1);
        st();
        chk("irq_busoff", 32'h1, 32'(irq_err));
        #1;
        chk("retry_busoff", 32'h0, 32'(auto_retry));
        node.idle(127);
        st();
        node.idle(1);
        {tec, rec, boff} = '0;
        st();
        rd(OFF_STATUS);
        chk("recovered", 32'h1, 32'(rdat[4]));
        apb(1'b1, OFF_CTRL, 32'h1);
        filt(11'h703);
        wrap_up();
    end
endmodule : can_rx_filter_error_state_test
